// [crr_return_unit.sv]
// return instruction execution sequencer
`timescale 1ns/1ps
module crr_return_unit
  import crr_pkg::*;
#(
  // instruction length in cycles
  parameter int unsigned RET_LEN = RET_CYCLES,
  // literal field width
  parameter int unsigned LIT_BITS = LIT_W
)
(
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // instruction fetch
  input wire logic [13:0] opcode_in,
  input wire logic opcode_valid_in,
  // call stack
  input wire logic [12:0] stack_top_entry_in,
  // interrupt control register
  input wire logic [7:0] interrupt_control_reg_in,
  // outputs
  output logic stack_pop_out,
  output logic pc_load_out,
  output logic [12:0] pc_value_out,
  output logic acc_we_out,
  output logic [7:0] acc_value_out,
  output logic irq_ctrl_we_out,
  output logic [7:0] irq_ctrl_value_out,
  output logic status_we_out,
  output logic flush_out,
  output logic busy_out
);
  crr_if dif ();
  crr_decoder u_dec (
    .opcode_in(opcode_in),
    .valid_in(opcode_valid_in),
    .dec(dif.dec)
  );

  // the sequencer serves only two cycle returns with byte literals
  if (RET_LEN != RET_CYCLES || LIT_BITS != LIT_W) begin : g_bad_cfg
    $error("return unit supports only two cycle returns, byte literals");
  end

  // interrupt control value with the global enable forced on
  function automatic logic [7:0] set_irq_en(input logic [7:0] ctrl);
    logic [7:0] r;
    r = ctrl;
    r[IRQ_EN_BIT] = 1'b1;
    return r;
  endfunction : set_irq_en

  // control group: sequencer state and one-cycle pulses
  crr_state_e state_q, state_d;
  logic pop_q, pop_d, pcl_q, pcl_d, accw_q, accw_d, icw_q, icw_d;
  logic stw_q, stw_d;
  logic take;

  // a return is taken only while none is in flight
  assign take = (state_q == CRR_ST_IDLE) && dif.hit;

  always_comb begin
    state_d = state_q;
    pop_d = 1'b0;
    pcl_d = 1'b0;
    accw_d = 1'b0;
    icw_d = 1'b0;
    stw_d = 1'b0;
    unique case (state_q)
      CRR_ST_IDLE: begin
        if (take) begin
          pop_d = 1'b1;
          pcl_d = 1'b1;
          state_d = CRR_ST_FLUSH;
          icw_d = (dif.kind == CRR_KIND_IRQ);
          accw_d = (dif.kind == CRR_KIND_LIT);
        end
      end
      CRR_ST_FLUSH: begin
        state_d = CRR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_q <= CRR_ST_IDLE;
      pop_q <= 1'b0;
      pcl_q <= 1'b0;
      accw_q <= 1'b0;
      icw_q <= 1'b0;
      stw_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pop_q <= pop_d;
      pcl_q <= pcl_d;
      accw_q <= accw_d;
      icw_q <= icw_d;
      stw_q <= stw_d;
    end
  end

  // data group: values for the pc, accumulator and control register
  logic [12:0] pc_q, pc_d;
  logic [7:0] acc_q, acc_d, ic_q, ic_d;

  always_comb begin
    pc_d = pc_q;
    acc_d = acc_q;
    ic_d = ic_q;
    if (take) begin
      pc_d = stack_top_entry_in;
      if (dif.kind == CRR_KIND_IRQ) begin
        ic_d = set_irq_en(interrupt_control_reg_in);
      end
      if (dif.kind == CRR_KIND_LIT) begin
        acc_d = dif.lit;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pc_q <= 13'h0000;
      acc_q <= 8'h00;
      ic_q <= 8'h00;
    end else begin
      pc_q <= pc_d;
      acc_q <= acc_d;
      ic_q <= ic_d;
    end
  end

  assign stack_pop_out = pop_q;
  assign pc_load_out = pcl_q;
  assign pc_value_out = pc_q;
  assign acc_we_out = accw_q;
  assign acc_value_out = acc_q;
  assign irq_ctrl_we_out = icw_q;
  assign irq_ctrl_value_out = ic_q;
  assign status_we_out = stw_q;
  assign flush_out = pop_q;
  assign busy_out = state_q == CRR_ST_FLUSH;

  chk_irq_ret_pop: assert property (
    @(posedge clock_in) disable iff (srst_in)
    take && dif.kind == CRR_KIND_IRQ
    |=> stack_pop_out && pc_load_out
    && pc_value_out == $past(stack_top_entry_in))
    else $error("interrupt return did not pop stack into pc");
  chk_irq_en_set: assert property (
    @(posedge clock_in) disable iff (srst_in)
    take && dif.kind == CRR_KIND_IRQ
    |=> irq_ctrl_we_out && irq_ctrl_value_out[IRQ_EN_BIT])
    else $error("interrupt return did not set global enable");
  chk_two_cycle_op: assert property (
    @(posedge clock_in) disable iff (srst_in)
    take
    |=> busy_out ##1 !busy_out)
    else $error("return did not take two cycles");
  chk_lit_to_acc: assert property (
    @(posedge clock_in) disable iff (srst_in)
    take && dif.kind == CRR_KIND_LIT
    |=> acc_we_out && acc_value_out == $past(opcode_in[7:0]))
    else $error("literal return did not load accumulator");
  chk_lit_pc_load: assert property (
    @(posedge clock_in) disable iff (srst_in)
    take && dif.kind == CRR_KIND_LIT
    |=> pc_load_out && pc_value_out == $past(stack_top_entry_in))
    else $error("literal return did not reload pc");
  chk_sub_keeps: assert property (
    @(posedge clock_in) disable iff (srst_in)
    take && dif.kind == CRR_KIND_SUB
    |=> pc_load_out && !acc_we_out && !irq_ctrl_we_out)
    else $error("plain return touched accumulator or enable");
  chk_no_status: assert property (
    @(posedge clock_in) disable iff (srst_in)
    pc_load_out |-> !status_we_out)
    else $error("return wrote status flags");
  chk_pop_single: assert property (
    @(posedge clock_in) disable iff (srst_in)
    stack_pop_out |=> !stack_pop_out)
    else $error("stack popped twice for one return");
  chk_busy_refuse: assert property (
    @(posedge clock_in) disable iff (srst_in)
    busy_out && opcode_valid_in
    |=> !stack_pop_out && !pc_load_out)
    else $error("return taken while another was in flight");
  chk_other_ignored: assert property (
    @(posedge clock_in) disable iff (srst_in)
    state_q == CRR_ST_IDLE && !dif.hit
    |=> !stack_pop_out && !busy_out)
    else $error("non-return word started a return");
  chk_sub_pc_value: assert property (
    @(posedge clock_in) disable iff (srst_in)
    take && dif.kind == CRR_KIND_SUB
    |=> pc_value_out == $past(stack_top_entry_in))
    else $error("plain return did not load stack top into pc");
  chk_sub_vals_kept: assert property (
    @(posedge clock_in) disable iff (srst_in)
    take && dif.kind == CRR_KIND_SUB
    |=> $stable(acc_value_out) && $stable(irq_ctrl_value_out))
    else $error("plain return changed accumulator or control value");
  chk_irq_acc_kept: assert property (
    @(posedge clock_in) disable iff (srst_in)
    take && dif.kind == CRR_KIND_IRQ
    |=> !acc_we_out && $stable(acc_value_out))
    else $error("interrupt return changed accumulator");
  chk_irq_low_kept: assert property (
    @(posedge clock_in) disable iff (srst_in)
    take && dif.kind == CRR_KIND_IRQ
    |=> irq_ctrl_value_out[IRQ_EN_BIT-1:0]
    == $past(interrupt_control_reg_in[IRQ_EN_BIT-1:0]))
    else $error("interrupt return altered other control bits");
  chk_lit_ctrl_kept: assert property (
    @(posedge clock_in) disable iff (srst_in)
    take && dif.kind == CRR_KIND_LIT
    |=> !irq_ctrl_we_out && $stable(irq_ctrl_value_out))
    else $error("literal return touched interrupt control");
  chk_values_hold: assert property (
    @(posedge clock_in) disable iff (srst_in)
    !take
    |=> $stable(pc_value_out) && $stable(acc_value_out)
    && $stable(irq_ctrl_value_out))
    else $error("value outputs changed without a return");
  chk_pop_busy: assert property (
    @(posedge clock_in) disable iff (srst_in)
    stack_pop_out |-> busy_out && flush_out)
    else $error("pop without flush and busy");
endmodule : crr_return_unit

// [crr_pkg.sv]
// constants for the core return instruction decoder
// Contract
// - interrupt return pops stack into program counter
// - interrupt return sets global irq enable, two cycles
// - literal return loads immediate into accumulator
// - literal return reloads pc from stack, two cycles
// - plain return pops stack, keeps accumulator, enable
package crr_pkg;
  localparam int unsigned OPC_W = 14;
  localparam int unsigned LIT_W = 8;
  localparam int unsigned IRQ_EN_BIT = 7;
  localparam logic [13:0] OPC_RET_IRQ = 14'h0009;
  localparam logic [13:0] OPC_RET_SUB = 14'h0008;
  localparam logic [3:0] OPC_RET_LIT_HI = 4'hd;
  localparam int unsigned RET_CYCLES = 2;
  typedef enum logic [1:0] {
    CRR_KIND_NONE = 2'b00,
    CRR_KIND_IRQ = 2'b01,
    CRR_KIND_LIT = 2'b10,
    CRR_KIND_SUB = 2'b11
  } crr_kind_e;
  typedef enum logic [0:0] {
    CRR_ST_IDLE = 1'b0,
    CRR_ST_FLUSH = 1'b1
  } crr_state_e;
  function automatic crr_kind_e crr_decode(input logic [13:0] opc);
    crr_kind_e k;
    k = CRR_KIND_NONE;
    if (opc == OPC_RET_IRQ) begin
      k = CRR_KIND_IRQ;
    end else if (opc == OPC_RET_SUB) begin
      k = CRR_KIND_SUB;
    end else if (opc[13:10] == OPC_RET_LIT_HI) begin
      k = CRR_KIND_LIT;
    end
    return k;
  endfunction : crr_decode
endpackage : crr_pkg

// [crr_if.sv]
// decode result carried from decoder to sequencer
`timescale 1ns/1ps
interface crr_if;
  logic hit;
  crr_pkg::crr_kind_e kind;
  logic [7:0] lit;
  modport dec (output hit, output kind, output lit);
  modport seq (input hit, input kind, input lit);
endinterface : crr_if

// [crr_decoder.sv]
// combinational opcode decoder for the return instructions
`timescale 1ns/1ps
module crr_decoder
  import crr_pkg::*;
(
  // fetched word
  input wire logic [13:0] opcode_in,
  input wire logic valid_in,
  // decode result
  crr_if.dec dec
);
  crr_kind_e kind;
  always_comb begin
    kind = crr_decode(opcode_in);
    dec.kind = kind;
    dec.hit = valid_in && (kind != CRR_KIND_NONE);
    dec.lit = opcode_in[7:0];
  end
endmodule : crr_decoder

// [testbench.sv]
// self-checking bench for the return instruction sequencer
`timescale 1ns/1ps
module testbench;
  import crr_pkg::*;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic [13:0] opcode_in = 14'h0000;
  logic opcode_valid_in = 1'b0;
  logic [12:0] stack_top_entry_in = 13'h0000;
  logic [7:0] interrupt_control_reg_in = 8'h00;
  logic stack_pop_out, pc_load_out, acc_we_out, irq_ctrl_we_out;
  logic status_we_out, flush_out, busy_out;
  logic [12:0] pc_value_out;
  logic [7:0] acc_value_out, irq_ctrl_value_out;
  logic [13:0] rnd_opc = 14'h0000;
  logic [7:0] exp_acc = 8'h00;
  logic [7:0] exp_ic = 8'h00;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  crr_return_unit crr_return_unit_inst (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .opcode_in(opcode_in),
    .opcode_valid_in(opcode_valid_in),
    .stack_top_entry_in(stack_top_entry_in),
    .interrupt_control_reg_in(interrupt_control_reg_in),
    .stack_pop_out(stack_pop_out),
    .pc_load_out(pc_load_out),
    .pc_value_out(pc_value_out),
    .acc_we_out(acc_we_out),
    .acc_value_out(acc_value_out),
    .irq_ctrl_we_out(irq_ctrl_we_out),
    .irq_ctrl_value_out(irq_ctrl_value_out),
    .status_we_out(status_we_out),
    .flush_out(flush_out),
    .busy_out(busy_out)
  );
  always #2 clock_in = ~clock_in;
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // expected kind: 1 interrupt, 2 literal, 3 plain, 0 none
  function automatic logic [1:0] kind_of(input logic [13:0] o);
    if (o == 14'h0009) return 2'h1;
    if (o == 14'h0008) return 2'h3;
    if (o[13:10] == 4'hd) return 2'h2;
    return 2'h0;
  endfunction : kind_of
  // one word offered at a falling edge, a return offered again while busy
  task automatic run(input logic [13:0] opc, input logic [12:0] ret_addr,
                     input logic [7:0] ic);
    logic [1:0] k;
    k = kind_of(opc);
    if (k == 2'h2) exp_acc = opc[7:0];
    if (k == 2'h1) exp_ic = ic | 8'h80;
    opcode_in = opc;
    opcode_valid_in = 1'b1;
    stack_top_entry_in = ret_addr;
    interrupt_control_reg_in = ic;
    @(negedge clock_in);
    opcode_in = 14'h0009;
    opcode_valid_in = (k != 2'h0);
    stack_top_entry_in = ~ret_addr;
    chk(stack_pop_out, k != 2'h0);
    chk(pc_load_out, k != 2'h0);
    chk(flush_out, k != 2'h0);
    chk(busy_out, k != 2'h0);
    chk(acc_we_out, k == 2'h2);
    chk(irq_ctrl_we_out, k == 2'h1);
    chk(status_we_out, 1'b0);
    if (k != 2'h0) chk(pc_value_out, ret_addr);
    if (k == 2'h2) chk(acc_value_out, opc[7:0]);
    if (k == 2'h1) chk(irq_ctrl_value_out, ic | 8'h80);
    @(negedge clock_in);
    opcode_valid_in = 1'b0;
    chk(stack_pop_out | pc_load_out | busy_out, 1'b0);
    chk(acc_we_out | irq_ctrl_we_out | status_we_out, 1'b0);
    if (k != 2'h0) chk(pc_value_out, ret_addr);
    chk(acc_value_out, exp_acc);
    chk(irq_ctrl_value_out, exp_ic);
    @(negedge clock_in);
  endtask : run
  initial begin
    void'($urandom(43792));
    repeat (10) @(negedge clock_in);
    chk(stack_pop_out | busy_out | pc_value_out, 13'h0000);
    srst_in = 1'b0;
    @(negedge clock_in);
    run(14'h0009, 13'h1fff, 8'h00);
    run(14'h0008, 13'h0001, 8'h7f);
    run(14'h3400, 13'h0abc, 8'h12);
    run(14'h37ff, 13'h1000, 8'hff);
    run(14'h000a, 13'h0123, 8'h00);
    run(14'h3800, 13'h0456, 8'h00);
    // reset in mid-run with a return offered: nothing taken, values cleared
    opcode_in = 14'h0009;
    opcode_valid_in = 1'b1;
    srst_in = 1'b1;
    @(negedge clock_in);
    chk(stack_pop_out | busy_out | irq_ctrl_we_out, 13'h0000);
    chk(pc_value_out | acc_value_out | irq_ctrl_value_out, 13'h0000);
    srst_in = 1'b0;
    opcode_valid_in = 1'b0;
    exp_acc = 8'h00;
    exp_ic = 8'h00;
    @(negedge clock_in);
    chk(stack_pop_out | busy_out | pc_load_out, 13'h0000);
    for (int i = 0; i < 300; i++) begin
      case ($urandom_range(3))
        0: rnd_opc = 14'h0009;
        1: rnd_opc = 14'h0008;
        2: rnd_opc = {4'hd, 10'($urandom)};
        default: rnd_opc = 14'($urandom);
      endcase
      run(rnd_opc, 13'($urandom), 8'($urandom));
    end
    summarize();
  end
endmodule : testbench
